//--- plpc_pkg.sv
// Constants and types for the link power and physical-layer configuration
// Functional notes
// - 16-bit L0s idle timeout in 4 ns units; counted here in clk_sys cycles
// - Zero L0s timeout never enters L0s
// - Re-enter L1 after idle re-entry delay in D3
// - Zero re-entry delay keeps link in L0R
// - First L1 entry immediate when all D3
// - 20-bit ASPM L1 entry timeout, 4 ns; counted here in clk_sys cycles
// - Zero ASPM L1 timeout never enters L1
// - Capture slot power limit when enabled, Endpoint
// - Retransmit PM_PME after microsecond timeout if unserviced
// - Send PME_TO_Ack after non-zero microsecond delay
// - Zero ack delay: user sends PME_TO_Ack
// - Port direction selects upstream or downstream
// - Link width one-hot x1 x2 x4 x8
// - Link speed one-hot Gen1 Gen2 Gen3
// - DC balance disable stops special symbols
// - Infer electrical idle after 128 us silence
// - FTS count chosen by common clock bit
// - Upconfigure disable removes upconfigure capability
// - Lane 0 equalization fields from 16-bit setting
// - Lanes 1 to 7 use same layout
package plpc_pkg;
	localparam int CLK_PERIOD_PS    = 10000;
	localparam int TICK_UNIT_PS     = 4000;
	localparam int US_PS            = 1000000;
	// Cycles per microsecond, rounded down but never below one
	localparam int US_CYCLES        = (US_PS / CLK_PERIOD_PS) < 1 ? 1
					  : (US_PS / CLK_PERIOD_PS);
	localparam int EI_INFER_US      = 128;
	localparam int L0S_W            = 16;
	localparam int L1RE_W           = 32;
	localparam int L1E_W            = 20;
	localparam int PME_W            = 20;
	localparam int ACK_W            = 16;
	localparam int EQ_W             = 16;
	localparam int LANES            = 8;
	localparam int DSP_LO           = 0;
	localparam int DSP_HI           = 3;
	localparam int DSH_LO           = 4;
	localparam int DSH_HI           = 6;
	localparam int USP_LO           = 8;
	localparam int USP_HI           = 11;
	localparam int USH_LO           = 12;
	localparam int USH_HI           = 14;
	localparam logic [3:0] WIDTH_X1 = 4'h1;
	localparam logic [3:0] WIDTH_X2 = 4'h2;
	localparam logic [3:0] WIDTH_X4 = 4'h4;
	localparam logic [3:0] WIDTH_X8 = 4'h8;
	localparam logic [2:0] SPEED_G1 = 3'h1;
	localparam logic [2:0] SPEED_G2 = 3'h2;
	localparam logic [2:0] SPEED_G3 = 3'h4;
	typedef enum logic [3:0] {
		PLPC_L0  = 4'h1,
		PLPC_L0S = 4'h2,
		PLPC_L1  = 4'h4,
		PLPC_L0R = 4'h8
	} plpc_lstate_t;
endpackage

//--- plpc_us_tick.sv
// Microsecond enable pulse divider
`timescale 1ns/10ps
`default_nettype none
module plpc_us_tick #(
	parameter int DIV = 100
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	output logic      tick
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	always_comb begin
		if (cnt_reg == 16'(DIV - 1))
			cnt_next = 16'h0;
		else
			cnt_next = cnt_reg + 16'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			cnt_reg <= 16'h0;
		else
			cnt_reg <= cnt_next;
	end
	assign tick = (cnt_reg == 16'(DIV - 1));
endmodule
`default_nettype wire

//--- plpc_core.sv
// Link power timers and physical-layer configuration decode
`timescale 1ns/10ps
`default_nettype none
module plpc_core
	import plpc_pkg::*;
#(
	parameter logic [plpc_pkg::L0S_W-1:0]  L0S_TIMEOUT = 16'h0100,
	parameter logic [plpc_pkg::L1RE_W-1:0] L1_REENTRY  = 32'h0000_0100,
	parameter logic [plpc_pkg::L1E_W-1:0]  L1_ENTRY    = 20'h00400,
	parameter logic [plpc_pkg::PME_W-1:0]  PME_TIMEOUT = 20'h00064,
	parameter logic [plpc_pkg::ACK_W-1:0]  ACK_DELAY   = 16'h0064,
	parameter int                          EI_US       = plpc_pkg::EI_INFER_US,
	parameter int                          US_DIV      = plpc_pkg::US_CYCLES
) (
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	// Static settings; timeouts, capture enable and idle inference disable latched at reset, the rest used live
	input  wire logic [L0S_W-1:0]        l0s_idle_timeout,
	input  wire logic [L1RE_W-1:0]       l1_reentry_delay,
	input  wire logic [L1E_W-1:0]        aspm_l1_entry_timeout,
	input  wire logic                    slot_power_capture_enable,
	input  wire logic [PME_W-1:0]        pme_retransmit_timeout,
	input  wire logic [ACK_W-1:0]        turnoff_ack_delay,
	input  wire logic                    port_direction_upstream,
	input  wire logic [3:0]              max_link_width_setting,
	input  wire logic [2:0]              max_link_speed_setting,
	input  wire logic                    dc_balance_disable,
	input  wire logic                    idle_inference_disable,
	input  wire logic [7:0]              fts_count_common_clk_rate1,
	input  wire logic [7:0]              fts_count_separate_clk_rate1,
	input  wire logic [7:0]              fts_count_common_clk_rate2,
	input  wire logic [7:0]              fts_count_separate_clk_rate2,
	input  wire logic [7:0]              fts_count_common_clk_rate3,
	input  wire logic [7:0]              fts_count_separate_clk_rate3,
	input  wire logic                    upconfigure_disable,
	input  wire logic [EQ_W-1:0]         lane_zero_equalization_setting,
	input  wire logic [EQ_W*(LANES-1)-1:0] lane_other_equalization_setting,
	// Link activity and events
	input  wire logic                    tx_active,
	input  wire logic                    rx_active,
	input  wire logic                    all_d3,
	input  wire logic                    partner_wake,
	input  wire logic                    common_clock_bit,
	input  wire logic                    rx_fc_or_skp,
	input  wire logic                    slot_msg_valid,
	input  wire logic [7:0]              slot_msg_value,
	input  wire logic [1:0]              slot_msg_scale,
	input  wire logic                    pme_request,
	input  wire logic                    pme_serviced,
	input  wire logic                    turnoff_received,
	// Results
	output logic [3:0]                   link_state,
	output logic                         send_idle_seq,
	output logic [7:0]                   slot_power_value,
	output logic [1:0]                   slot_power_scale,
	output logic                         pme_send,
	output logic                         pme_to_ack_send,
	output logic                         is_upstream_port,
	output logic [3:0]                   link_width_lanes,
	output logic                         link_width_reserved,
	output logic [2:0]                   link_speed_gen,
	output logic                         link_speed_reserved,
	output logic                         dc_balance_active,
	output logic                         elec_idle_inferred,
	output logic [7:0]                   fts_rate1,
	output logic [7:0]                   fts_rate2,
	output logic [7:0]                   fts_rate3,
	output logic                         upconfigure_capable,
	output logic [EQ_W*LANES-1:0]        lane_eq_entry
);
	import plpc_pkg::*;

	function automatic logic [EQ_W-1:0] eq_fields(input logic [EQ_W-1:0] s);
		eq_fields = '0;
		eq_fields[DSP_HI:DSP_LO] = s[DSP_HI:DSP_LO];
		eq_fields[DSH_HI:DSH_LO] = s[DSH_HI:DSH_LO];
		eq_fields[USP_HI:USP_LO] = s[USP_HI:USP_LO];
		eq_fields[USH_HI:USH_LO] = s[USH_HI:USH_LO];
	endfunction

	logic us_tick;
	plpc_us_tick #(.DIV(US_DIV)) u_tick (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.tick    (us_tick)
	);

	// Settings captured at reset and held static
	logic [L0S_W-1:0]  l0s_cfg_reg;
	logic [L1RE_W-1:0] l1re_cfg_reg;
	logic [L1E_W-1:0]  l1e_cfg_reg;
	logic [PME_W-1:0]  pme_cfg_reg;
	logic [ACK_W-1:0]  ack_cfg_reg;
	logic              cap_cfg_reg;
	logic              ein_dis_reg;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			l0s_cfg_reg <= l0s_idle_timeout;
			l1re_cfg_reg <= l1_reentry_delay;
			l1e_cfg_reg <= aspm_l1_entry_timeout;
			pme_cfg_reg <= pme_retransmit_timeout;
			ack_cfg_reg <= turnoff_ack_delay;
			cap_cfg_reg <= slot_power_capture_enable;
			ein_dis_reg <= idle_inference_disable;
		end
	end

	// Link power state machine
	plpc_lstate_t st_reg, st_next;
	logic [L1RE_W-1:0] idle_reg, idle_next;
	logic              first_l1_reg, first_l1_next;
	logic [L0S_W-1:0]  txi_reg, txi_next;
	logic              idle_now;
	assign idle_now = !tx_active && !rx_active;
	always_comb begin
		st_next = st_reg;
		idle_next = idle_now ? idle_reg + 32'h1 : 32'h0;
		txi_next = tx_active ? '0 : txi_reg + 16'h1;
		first_l1_next = first_l1_reg;
		if (!all_d3)
			first_l1_next = 1'b0;
		case (st_reg)
			PLPC_L0: begin
				if (all_d3 && !first_l1_reg) begin
					st_next = PLPC_L1;
					first_l1_next = 1'b1;
					idle_next = 32'h0;
				end else if (!all_d3 && l1e_cfg_reg != '0 && idle_now
					&& idle_reg + 32'h1 >= 32'(l1e_cfg_reg)) begin
					st_next = PLPC_L1;
					idle_next = 32'h0;
				end else if (!all_d3 && l0s_cfg_reg != '0 && !tx_active
					&& txi_reg + 16'h1 >= l0s_cfg_reg)
					st_next = PLPC_L0S;
			end
			PLPC_L0S: begin
				if (tx_active || rx_active)
					st_next = PLPC_L0;
			end
			PLPC_L1: begin
				if (partner_wake) begin
					st_next = all_d3 ? PLPC_L0R : PLPC_L0;
					idle_next = 32'h0;
				end
			end
			PLPC_L0R: begin
				if (!all_d3)
					st_next = PLPC_L0;
				else if (l1re_cfg_reg != '0 && idle_now
					&& idle_reg + 32'h1 >= l1re_cfg_reg) begin
					st_next = PLPC_L1;
					idle_next = 32'h0;
				end
			end
			default: st_next = PLPC_L0;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_reg <= PLPC_L0;
			idle_reg <= 32'h0;
			txi_reg <= '0;
			first_l1_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			idle_reg <= idle_next;
			txi_reg <= txi_next;
			first_l1_reg <= first_l1_next;
		end
	end
	assign link_state = st_reg;
	assign send_idle_seq = (st_reg == PLPC_L0S);

	// Slot power limit capture
	logic [7:0] spv_reg, spv_next;
	logic [1:0] sps_reg, sps_next;
	always_comb begin
		spv_next = spv_reg;
		sps_next = sps_reg;
		if (slot_msg_valid && cap_cfg_reg && port_direction_upstream) begin
			spv_next = slot_msg_value;
			sps_next = slot_msg_scale;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			spv_reg <= 8'h0;
			sps_reg <= 2'h0;
		end else begin
			spv_reg <= spv_next;
			sps_reg <= sps_next;
		end
	end
	assign slot_power_value = spv_reg;
	assign slot_power_scale = sps_reg;

	// PME retransmit, turn-off acknowledge and idle inference timers
	logic              pme_pend_reg, pme_pend_next;
	logic [PME_W-1:0]  pme_cnt_reg, pme_cnt_next;
	logic              pme_send_reg, pme_send_next;
	logic              ack_pend_reg, ack_pend_next;
	logic [ACK_W-1:0]  ack_cnt_reg, ack_cnt_next;
	logic              ack_send_reg, ack_send_next;
	logic [7:0]        ei_cnt_reg, ei_cnt_next;
	logic              ei_reg, ei_next;
	always_comb begin
		pme_pend_next = pme_pend_reg;
		pme_cnt_next = pme_cnt_reg;
		pme_send_next = 1'b0;
		if (pme_request) begin
			pme_pend_next = 1'b1;
			pme_cnt_next = '0;
			pme_send_next = 1'b1;
		end else if (pme_serviced) begin
			pme_pend_next = 1'b0;
		end else if (pme_pend_reg && us_tick) begin
			if (pme_cnt_reg + 20'h1 >= pme_cfg_reg) begin
				pme_send_next = 1'b1;
				pme_cnt_next = '0;
			end else
				pme_cnt_next = pme_cnt_reg + 20'h1;
		end
		ack_pend_next = ack_pend_reg;
		ack_cnt_next = ack_cnt_reg;
		ack_send_next = 1'b0;
		if (turnoff_received && ack_cfg_reg != '0) begin
			ack_pend_next = 1'b1;
			ack_cnt_next = '0;
		end else if (ack_pend_reg && us_tick) begin
			if (ack_cnt_reg + 16'h1 >= ack_cfg_reg) begin
				ack_send_next = 1'b1;
				ack_pend_next = 1'b0;
			end else
				ack_cnt_next = ack_cnt_reg + 16'h1;
		end
		ei_cnt_next = ei_cnt_reg;
		ei_next = ei_reg;
		if (st_reg != PLPC_L0 || ein_dis_reg || rx_fc_or_skp) begin
			ei_cnt_next = 8'h0;
			ei_next = 1'b0;
		end else if (us_tick && !ei_reg) begin
			if (ei_cnt_reg + 8'h1 >= 8'(EI_US))
				ei_next = 1'b1;
			else
				ei_cnt_next = ei_cnt_reg + 8'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pme_pend_reg <= 1'b0;
			pme_cnt_reg <= '0;
			pme_send_reg <= 1'b0;
			ack_pend_reg <= 1'b0;
			ack_cnt_reg <= '0;
			ack_send_reg <= 1'b0;
			ei_cnt_reg <= 8'h0;
			ei_reg <= 1'b0;
		end else begin
			pme_pend_reg <= pme_pend_next;
			pme_cnt_reg <= pme_cnt_next;
			pme_send_reg <= pme_send_next;
			ack_pend_reg <= ack_pend_next;
			ack_cnt_reg <= ack_cnt_next;
			ack_send_reg <= ack_send_next;
			ei_cnt_reg <= ei_cnt_next;
			ei_reg <= ei_next;
		end
	end
	assign pme_send = pme_send_reg;
	assign pme_to_ack_send = ack_send_reg;
	assign elec_idle_inferred = ei_reg;

	// Static physical-layer decode
	always_comb begin
		is_upstream_port = port_direction_upstream;
		link_width_reserved = 1'b0;
		case (max_link_width_setting)
			WIDTH_X1: link_width_lanes = 4'h1;
			WIDTH_X2: link_width_lanes = 4'h2;
			WIDTH_X4: link_width_lanes = 4'h4;
			WIDTH_X8: link_width_lanes = 4'h8;
			default: begin
				link_width_lanes = 4'h1;
				link_width_reserved = 1'b1;
			end
		endcase
		link_speed_reserved = 1'b0;
		case (max_link_speed_setting)
			SPEED_G1: link_speed_gen = 3'h1;
			SPEED_G2: link_speed_gen = 3'h2;
			SPEED_G3: link_speed_gen = 3'h3;
			default: begin
				link_speed_gen = 3'h1;
				link_speed_reserved = 1'b1;
			end
		endcase
		dc_balance_active = !dc_balance_disable;
		upconfigure_capable = !upconfigure_disable;
		fts_rate1 = common_clock_bit ? fts_count_common_clk_rate1
			: fts_count_separate_clk_rate1;
		fts_rate2 = common_clock_bit ? fts_count_common_clk_rate2
			: fts_count_separate_clk_rate2;
		fts_rate3 = common_clock_bit ? fts_count_common_clk_rate3
			: fts_count_separate_clk_rate3;
		lane_eq_entry = '0;
		lane_eq_entry[EQ_W-1:0] = eq_fields(lane_zero_equalization_setting);
		for (int i = 1; i < LANES; i++)
			lane_eq_entry[i*EQ_W +: EQ_W] = eq_fields(
				lane_other_equalization_setting[(i-1)*EQ_W +: EQ_W]);
	end

	l0s_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		l0s_cfg_reg == '0 |-> st_reg != PLPC_L0S)
		else $error("L0s entered with zero timeout");
	l1_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		st_reg == PLPC_L0R && l1re_cfg_reg == '0 && all_d3
		|=> st_reg == PLPC_L0R)
		else $error("L1 re-entered with zero delay");
	first_l1_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		st_reg == PLPC_L0 && all_d3 && !first_l1_reg
		|=> st_reg == PLPC_L1)
		else $error("First L1 entry not immediate");
	ack_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ack_cfg_reg == '0 |-> !pme_to_ack_send)
		else $error("Ack sent with zero delay");
	slot_cap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!cap_cfg_reg |=> $stable(slot_power_value))
		else $error("Slot power captured while disabled");
	ei_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ein_dis_reg |-> !elec_idle_inferred)
		else $error("Idle inferred while disabled");
	fts_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		common_clock_bit |-> fts_rate1 == fts_count_common_clk_rate1)
		else $error("FTS count not common-clock value");
	pme_tx_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pme_request |=> pme_send)
		else $error("PM_PME not sent on request");
endmodule
`default_nettype wire

//--- plpc_far.sv
// Remote port model driving link events into the power block
`timescale 1ns/10ps
`default_nettype none
module plpc_far (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	output logic            rx_active,
	output logic            partner_wake,
	output logic            rx_fc_or_skp,
	output logic            slot_msg_valid,
	output logic [7:0]      slot_msg_value,
	output logic [1:0]      slot_msg_scale,
	output logic            turnoff_received
);
	logic       skp_on;
	logic [1:0] div;
	initial begin
		{rx_active, partner_wake, rx_fc_or_skp, slot_msg_valid} = 4'h0;
		{slot_msg_value, slot_msg_scale, turnoff_received} = 11'h0;
		skp_on = 1'b1;
		div = 2'h0;
	end
	// SKP every fourth cycle keeps idle inference quiet while it runs
	always @(negedge clk_sys) begin
		div <= div + 2'h1;
		rx_fc_or_skp <= reset_n && skp_on && (div == 2'h0);
	end
	task automatic wake();
		partner_wake = 1'b1;
		@(negedge clk_sys);
		partner_wake = 1'b0;
		@(negedge clk_sys);
	endtask
	// Message fields show garbage once the valid pulse is gone
	task automatic slot(input logic [7:0] v, input logic [1:0] s);
		slot_msg_valid = 1'b1;
		slot_msg_value = v;
		slot_msg_scale = s;
		@(negedge clk_sys);
		slot_msg_valid = 1'b0;
		slot_msg_value = ~v;
		slot_msg_scale = ~s;
	endtask
	task automatic turnoff();
		turnoff_received = 1'b1;
		@(negedge clk_sys);
		turnoff_received = 1'b0;
	endtask
	// One cycle of receive-side traffic
	task automatic rx_burst();
		rx_active = 1'b1;
		@(negedge clk_sys);
		rx_active = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the link power and physical-layer block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import plpc_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
	err_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, g, e); end end
	logic                  clk_sys = 1'b0;
	logic                  reset_n = 1'b0;
	logic [L0S_W-1:0]      l0s_idle_timeout;
	logic [L1RE_W-1:0]     l1_reentry_delay;
	logic [L1E_W-1:0]      aspm_l1_entry_timeout;
	logic [PME_W-1:0]      pme_retransmit_timeout;
	logic [ACK_W-1:0]      turnoff_ack_delay;
	logic [EQ_W-1:0]       lane_zero_equalization_setting;
	logic [EQ_W*7-1:0]     lane_other_equalization_setting;
	logic [EQ_W*LANES-1:0] lane_eq_entry;
	logic [3:0]            max_link_width_setting, link_state, link_width_lanes;
	logic [2:0]            max_link_speed_setting, link_speed_gen;
	logic [7:0]            fts_count_common_clk_rate1, fts_count_common_clk_rate2;
	logic [7:0]            fts_count_common_clk_rate3, fts_count_separate_clk_rate1;
	logic [7:0]            fts_count_separate_clk_rate2, fts_count_separate_clk_rate3;
	logic [7:0]            fts_rate1, fts_rate2, fts_rate3, slot_msg_value;
	logic [7:0]            slot_power_value;
	logic [1:0]            slot_msg_scale, slot_power_scale;
	logic                  slot_power_capture_enable, port_direction_upstream;
	logic                  dc_balance_disable, idle_inference_disable;
	logic                  upconfigure_disable, tx_active, rx_active, all_d3;
	logic                  partner_wake, common_clock_bit, rx_fc_or_skp;
	logic                  slot_msg_valid, pme_request, pme_serviced;
	logic                  turnoff_received, send_idle_seq, pme_send;
	logic                  pme_to_ack_send, is_upstream_port, link_width_reserved;
	logic                  link_speed_reserved, dc_balance_active;
	logic                  elec_idle_inferred, upconfigure_capable;
	int                    err_count = 0;
	int                    comparisons = 0;
	int                    pme_cnt, ack_cnt;

	plpc_core #(.US_DIV(2), .EI_US(4)) dut (.clk_sys, .reset_n,
		.l0s_idle_timeout, .l1_reentry_delay, .aspm_l1_entry_timeout,
		.slot_power_capture_enable, .pme_retransmit_timeout,
		.turnoff_ack_delay, .port_direction_upstream, .max_link_width_setting,
		.max_link_speed_setting, .dc_balance_disable, .idle_inference_disable,
		.fts_count_common_clk_rate1, .fts_count_separate_clk_rate1,
		.fts_count_common_clk_rate2, .fts_count_separate_clk_rate2,
		.fts_count_common_clk_rate3, .fts_count_separate_clk_rate3,
		.upconfigure_disable, .lane_zero_equalization_setting,
		.lane_other_equalization_setting, .tx_active, .rx_active, .all_d3,
		.partner_wake, .common_clock_bit, .rx_fc_or_skp, .slot_msg_valid,
		.slot_msg_value, .slot_msg_scale, .pme_request, .pme_serviced,
		.turnoff_received, .link_state, .send_idle_seq, .slot_power_value,
		.slot_power_scale, .pme_send, .pme_to_ack_send, .is_upstream_port,
		.link_width_lanes, .link_width_reserved, .link_speed_gen,
		.link_speed_reserved, .dc_balance_active, .elec_idle_inferred,
		.fts_rate1, .fts_rate2, .fts_rate3, .upconfigure_capable,
		.lane_eq_entry);

	plpc_far far (.clk_sys, .reset_n, .rx_active, .partner_wake, .rx_fc_or_skp,
		.slot_msg_valid, .slot_msg_value, .slot_msg_scale, .turnoff_received);

	always #5 clk_sys = ~clk_sys;

	always @(negedge clk_sys) begin
		pme_cnt += int'(pme_send === 1'b1);
		ack_cnt += int'(pme_to_ack_send === 1'b1);
	end

	function automatic logic [15:0] eqv(input int i);
		return 16'hf7d5 ^ 16'(i * 32'h1111);
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic wrap_up();
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Timed settings only take effect through a reset
	task automatic start(input logic a, input logic l1_on);
		l0s_idle_timeout = a ? 16'h0008 : 16'h0000;
		l1_reentry_delay = a ? 32'h0000_0006 : 32'h0000_0000;
		aspm_l1_entry_timeout = l1_on ? 20'h0000c : 20'h00000;
		slot_power_capture_enable = a;
		turnoff_ack_delay = a ? 16'h0004 : 16'h0000;
		idle_inference_disable = ~a;
		tx_active = 1'b1;
		all_d3 = 1'b0;
		reset_n = 1'b0;
		cyc(6);
		`CHK(link_state, 4'h1)
		reset_n = 1'b1;
		pme_cnt = 0;
		ack_cnt = 0;
	endtask

	task automatic decode_check();
		for (int k = 0; k < 4; k++) begin
			max_link_width_setting = 4'h1 << k;
			max_link_speed_setting = 3'h1 << (k % 3);
			port_direction_upstream = k[0];
			dc_balance_disable = k[0];
			upconfigure_disable = k[1];
			common_clock_bit = k[0];
			cyc(1);
			`CHK(link_width_lanes, 4'h1 << k)
			`CHK(link_width_reserved, 1'b0)
			`CHK(link_speed_gen, 3'(k % 3 + 1))
			`CHK(link_speed_reserved, 1'b0)
			`CHK(is_upstream_port, k[0])
			`CHK(dc_balance_active, ~k[0])
			`CHK(upconfigure_capable, ~k[1])
			`CHK(fts_rate1, k[0] ? 8'h11 : 8'h21)
			`CHK(fts_rate2, k[0] ? 8'h12 : 8'h22)
			`CHK(fts_rate3, k[0] ? 8'h13 : 8'h23)
		end
		max_link_width_setting = 4'h3;
		max_link_speed_setting = 3'h6;
		cyc(1);
		`CHK(link_width_reserved, 1'b1)
		`CHK(link_speed_reserved, 1'b1)
		for (int i = 0; i < LANES; i++)
			`CHK(lane_eq_entry[i*16 +: 16], eqv(i) & 16'h7f7f)
	endtask

	initial begin
		{pme_request, pme_serviced, common_clock_bit} = 3'h0;
		pme_retransmit_timeout = 20'h00003;
		{fts_count_common_clk_rate1, fts_count_separate_clk_rate1} = 16'h1121;
		{fts_count_common_clk_rate2, fts_count_separate_clk_rate2} = 16'h1222;
		{fts_count_common_clk_rate3, fts_count_separate_clk_rate3} = 16'h1323;
		lane_zero_equalization_setting = eqv(0);
		for (int i = 1; i < LANES; i++)
			lane_other_equalization_setting[(i-1)*16 +: 16] = eqv(i);
		start(1'b1, 1'b0);
		decode_check();
		pme_request = 1'b1;
		cyc(1);
		pme_request = 1'b0;
		`CHK(pme_send, 1'b1)
		cyc(10);
		`CHK(pme_cnt, 2)
		pme_serviced = 1'b1;
		cyc(1);
		pme_serviced = 1'b0;
		cyc(20);
		`CHK(pme_cnt, 2)
		far.turnoff();
		cyc(5);
		`CHK(ack_cnt, 0)
		cyc(7);
		`CHK(ack_cnt, 1)
		far.slot(8'hc5, 2'h2);
		cyc(2);
		`CHK(slot_power_value, 8'hc5)
		`CHK(slot_power_scale, 2'h2)
		port_direction_upstream = 1'b0;
		far.slot(8'h5a, 2'h1);
		cyc(2);
		`CHK(slot_power_value, 8'hc5)
		port_direction_upstream = 1'b1;
		cyc(20);
		`CHK(elec_idle_inferred, 1'b0)
		far.skp_on = 1'b0;
		cyc(14);
		`CHK(elec_idle_inferred, 1'b1)
		far.skp_on = 1'b1;
		tx_active = 1'b0;
		far.rx_burst();
		cyc(6);
		`CHK(link_state, 4'h1)
		cyc(3);
		`CHK(link_state, 4'h2)
		`CHK(send_idle_seq, 1'b1)
		cyc(40);
		`CHK(link_state, 4'h2)
		tx_active = 1'b1;
		cyc(2);
		`CHK(link_state, 4'h1)
		all_d3 = 1'b1;
		cyc(1);
		`CHK(link_state, 4'h4)
		far.wake();
		`CHK(link_state, 4'h8)
		tx_active = 1'b0;
		cyc(4);
		`CHK(link_state, 4'h8)
		far.rx_burst();
		cyc(4);
		`CHK(link_state, 4'h8)
		cyc(2);
		`CHK(link_state, 4'h4)
		start(1'b0, 1'b1);
		far.turnoff();
		cyc(20);
		`CHK(ack_cnt, 0)
		far.slot(8'h3a, 2'h1);
		cyc(2);
		`CHK(slot_power_value, 8'h00)
		far.skp_on = 1'b0;
		cyc(14);
		`CHK(elec_idle_inferred, 1'b0)
		far.skp_on = 1'b1;
		tx_active = 1'b0;
		cyc(11);
		`CHK(link_state, 4'h1)
		cyc(3);
		`CHK(link_state, 4'h4)
		start(1'b0, 1'b0);
		tx_active = 1'b0;
		cyc(20);
		`CHK(link_state, 4'h1)
		all_d3 = 1'b1;
		cyc(1);
		`CHK(link_state, 4'h4)
		far.wake();
		tx_active = 1'b0;
		cyc(30);
		`CHK(link_state, 4'h8)
		wrap_up();
	end

	// The whole sequence needs well under 10 us
	initial begin
		#20us;
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
